// ==== akd_adc_model.sv ====
// converter result and strobe source standing beside the key decoder
// assumes the bench asks for one sample per request on i_go
`timescale 1ns/1ps
`default_nettype none
module akd_adc_model (
    input  wire logic                         i_clk,
    input  wire logic                         i_rst,
    input  wire logic                         i_go,
    input  wire logic [akd_pkg::SAMPLE_W-1:0] i_value,
    output logic                              o_sample_strobe,
    output logic      [akd_pkg::SAMPLE_W-1:0] o_conversion_result
);
    // ************************************************************
    // sample delivery
    // ************************************************************
    logic [akd_pkg::SAMPLE_W-1:0] last;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            last <= 8'h55;
        end else if (i_go) begin
            last <= i_value;
        end
    end

    // one pulse per request, paced by the bench
    assign o_sample_strobe     = i_go;
    // outside the strobe the result is stale, so show its inverse
    assign o_conversion_result = i_go ? i_value : ~last;
endmodule // akd_adc_model
`default_nettype wire

// ==== akd_debounce.sv ====
// analog key decoder with five-sample debounce and sticky change flag
// assumes strobe and clear come from logic on i_clk, one cycle wide
`timescale 1ns/1ps
`default_nettype none
module akd_debounce #(
    parameter int unsigned DEBOUNCE_COUNT = akd_pkg::DEBOUNCE_COUNT_INIT
) (
    input  wire logic                           i_clk,
    input  wire logic                           i_rst,
    input  wire logic                           i_ce,
    input  wire logic                           i_sample_strobe,
    input  wire logic [akd_pkg::SAMPLE_W-1:0]   i_conversion_result,
    input  wire logic                           i_key_changed_clear,
    output logic      [akd_pkg::KEY_CODE_W-1:0] o_stable_key_code,
    output logic      [akd_pkg::KEY_CODE_W-1:0] o_previous_key_code,
    output logic                                o_key_changed_flag,
    output logic                                o_debounce_done_flag
);
    // ************************************************************
    // parameter check
    // ************************************************************
    localparam int unsigned CNT_W = $clog2(DEBOUNCE_COUNT + 1);
    localparam logic [CNT_W-1:0] CNT_INIT   = CNT_W'(DEBOUNCE_COUNT);
    localparam logic [CNT_W-1:0] CNT_RELOAD = CNT_W'(DEBOUNCE_COUNT - 1);
    localparam logic [CNT_W-1:0] CNT_ONE    = CNT_W'(1);

    // a count of one would reload to zero and wrap before it settles
    if (DEBOUNCE_COUNT < 2) begin : g_bad_count
        $error("DEBOUNCE_COUNT must be at least 2");
    end

    // ************************************************************
    // state
    // ************************************************************
    logic [akd_pkg::KEY_CODE_W-1:0] stable_key_code;
    logic [akd_pkg::KEY_CODE_W-1:0] previous_key_code;
    logic [CNT_W-1:0]               debounce_counter;
    logic                           debounce_done_flag;
    logic                           key_changed_flag;

    logic [akd_pkg::KEY_CODE_W-1:0] next_stable_key_code;
    logic [akd_pkg::KEY_CODE_W-1:0] next_previous_key_code;
    logic [CNT_W-1:0]               next_debounce_counter;
    logic                           next_debounce_done_flag;
    logic                           next_key_changed_flag;

    // ************************************************************
    // decode
    // ************************************************************
    logic [akd_pkg::KEY_CODE_W-1:0] decoded;

    akd_key_decode u_decode (
        .i_conversion_result (i_conversion_result),
        .o_key_code          (decoded)
    );

    // ************************************************************
    // sample qualification
    // ************************************************************
    logic take;
    logic same_code;
    logic counting;
    logic settling;
    logic key_moved;
    logic set_changed;

    assign take      = i_ce & i_sample_strobe;
    assign same_code = (decoded == previous_key_code);
    assign counting  = take & same_code & ~debounce_done_flag;
    // last equal sample of the run; counter at one goes to zero
    assign settling  = counting & (debounce_counter == CNT_ONE);
    assign key_moved = (previous_key_code != stable_key_code);
    assign set_changed = settling & key_moved;

    // ************************************************************
    // next values
    // ************************************************************
    assign next_previous_key_code = (take & ~same_code) ? decoded
                                  : previous_key_code;

    assign next_debounce_counter =
        (take & ~same_code) ? CNT_RELOAD
      : counting            ? debounce_counter - CNT_ONE
      :                       debounce_counter;

    assign next_debounce_done_flag =
        (take & ~same_code) ? 1'b0
      : settling            ? 1'b1
      :                       debounce_done_flag;

    assign next_stable_key_code = set_changed ? previous_key_code
                                : stable_key_code;

    // set wins over a clear in the same cycle; no self clear
    assign next_key_changed_flag =
        set_changed ? 1'b1
      : (i_ce & i_key_changed_clear) ? 1'b0
      : key_changed_flag;

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            stable_key_code    <= akd_pkg::NO_KEY_CODE;
            previous_key_code  <= akd_pkg::NO_KEY_CODE;
            debounce_counter   <= CNT_INIT;
            debounce_done_flag <= akd_pkg::DEBOUNCE_DONE_RESET;
            key_changed_flag   <= akd_pkg::KEY_CHANGED_RESET;
        end else if (i_ce) begin
            stable_key_code    <= next_stable_key_code;
            previous_key_code  <= next_previous_key_code;
            debounce_counter   <= next_debounce_counter;
            debounce_done_flag <= next_debounce_done_flag;
            key_changed_flag   <= next_key_changed_flag;
        end
    end

    assign o_stable_key_code    = stable_key_code;
    assign o_previous_key_code  = previous_key_code;
    assign o_key_changed_flag   = key_changed_flag;
    assign o_debounce_done_flag = debounce_done_flag;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_new_code;
        take && !same_code;
    endsequence

    sequence s_equal_run;
        take && same_code && !debounce_done_flag;
    endsequence

    sequence s_settled;
        take && same_code && debounce_done_flag;
    endsequence

    logic [CNT_W-1:0] cnt_less;
    assign cnt_less = debounce_counter - CNT_ONE;

    // independent run length of equal samples, saturating at the count
    logic [CNT_W-1:0] run_len;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            run_len <= '0;
        end else if (take & ~same_code) begin
            run_len <= CNT_ONE;
        end else if (take & (run_len != CNT_INIT)) begin
            run_len <= run_len + CNT_ONE;
        end
    end

    no_key_map_a: assert property (
        take && (i_conversion_result >= 8'hF8)
        |=> previous_key_code == akd_pkg::NO_KEY_CODE)
        else $error("near-supply sample did not decode to no key");

    step_map_a: assert property (
        (s_new_code and (i_conversion_result < 8'hF8))
        |=> previous_key_code
            == {1'b0, 4'($past(i_conversion_result + 8'h08) >> 4)})
        else $error("key code does not match rounded upper nibble");

    reload_cnt_a: assert property (
        s_new_code
        |=> debounce_counter == CNT_RELOAD && !debounce_done_flag)
        else $error("new code did not reload counter and clear done");

    count_down_a: assert property (
        s_equal_run |=> debounce_counter == $past(cnt_less))
        else $error("equal sample did not decrement counter");

    settled_hold_a: assert property (
        s_settled
        |=> debounce_done_flag && $stable(debounce_counter)
            && $stable(stable_key_code))
        else $error("settled code changed state on equal sample");

    five_in_row_a: assert property (
        debounce_done_flag |-> run_len == CNT_INIT)
        else $error("code accepted before five equal samples");

    stable_update_a: assert property (
        (s_equal_run and (debounce_counter == CNT_ONE && key_moved))
        |=> stable_key_code == $past(previous_key_code)
            && key_changed_flag && debounce_done_flag)
        else $error("settled new code not taken or not flagged");

    sticky_flag_a: assert property (
        key_changed_flag && !(i_ce && i_key_changed_clear)
        |=> key_changed_flag)
        else $error("change flag dropped without host clear");

    flag_clear_a: assert property (
        i_ce && i_key_changed_clear && !set_changed
        |=> !key_changed_flag)
        else $error("host clear did not drop change flag");

    idle_hold_a: assert property (
        !take
        |=> $stable(previous_key_code) && $stable(debounce_counter)
            && $stable(stable_key_code) && $stable(debounce_done_flag))
        else $error("state moved without a sample strobe");

    reset_init_a: assert property (
        @(posedge i_clk) disable iff (1'b0)
        i_rst
        |=> stable_key_code == akd_pkg::NO_KEY_CODE
            && previous_key_code == akd_pkg::NO_KEY_CODE
            && debounce_counter == CNT_INIT
            && !debounce_done_flag && !key_changed_flag)
        else $error("reset values wrong");
endmodule // akd_debounce
`default_nettype wire

// ==== akd_key_decode.sv ====
// decode stage: one conversion result to one key code
// assumes the caller samples the code on its own strobe
`timescale 1ns/1ps
`default_nettype none
module akd_key_decode (
    input  wire logic [akd_pkg::SAMPLE_W-1:0]   i_conversion_result,
    output logic      [akd_pkg::KEY_CODE_W-1:0] o_key_code
);
    // ************************************************************
    // rounding add and step select
    // ************************************************************
    logic [akd_pkg::SAMPLE_W:0]           rounded;
    logic                                 overflow;
    logic [akd_pkg::KEY_CODE_W-2:0]       step;

    // half-step offset centres each key's window on its level
    assign rounded  = {1'b0, i_conversion_result}
                    + {1'b0, akd_pkg::ROUND_OFFSET};
    assign overflow = rounded[akd_pkg::SAMPLE_W];
    // sixteen equal steps, code is the upper nibble
    assign step     = rounded[akd_pkg::SAMPLE_W-1:akd_pkg::STEP_LSB];
    // near-supply input wraps past full scale and reads as no key
    assign o_key_code = overflow ? akd_pkg::NO_KEY_CODE
                                 : {1'b0, step};
endmodule // akd_key_decode
`default_nettype wire

// ==== akd_pkg.sv ====
// constants shared by the analog key decoder and its decode stage
// assumes 8-bit conversion results and a 5-bit key code space
package akd_pkg;
    // ************************************************************
    // widths
    // ************************************************************
    localparam int unsigned SAMPLE_W   = 8;
    localparam int unsigned KEY_CODE_W = 5;

    // ************************************************************
    // decode constants
    // ************************************************************
    localparam logic [KEY_CODE_W-1:0] NO_KEY_CODE  = 5'h10;
    localparam logic [SAMPLE_W-1:0]   ROUND_OFFSET = 8'h08;
    localparam int unsigned           STEP_LSB     = 4;

    // ************************************************************
    // debounce constants and reset values
    // ************************************************************
    localparam int unsigned DEBOUNCE_COUNT_INIT = 5;
    localparam logic        KEY_CHANGED_RESET   = 1'b0;
    localparam logic        DEBOUNCE_DONE_RESET = 1'b0;
endpackage

// ==== tb_top.sv ====
// self-checking bench for the analog key decoder
// assumes the converter model in akd_adc_model.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
    n_errors++; $display("BAD %s expected %h seen %h", nm, e, g); end end
module tb_top;
    // ************************************************************
    // signals and instances
    // ************************************************************
    logic       clk, rst, ce, go, clr;
    logic [7:0] val, lo, hi;
    wire  logic       strobe, chg, done;
    wire  logic [7:0] res;
    wire  logic [4:0] stable, prev;
    int n_errors = 0;
    int num_checks = 0;

    akd_adc_model akd_adc_model_i (.i_clk(clk), .i_rst(rst), .i_go(go),
        .i_value(val), .o_sample_strobe(strobe),
        .o_conversion_result(res));
    akd_debounce akd_debounce_i (.i_clk(clk), .i_rst(rst), .i_ce(ce),
        .i_sample_strobe(strobe), .i_conversion_result(res),
        .i_key_changed_clear(clr), .o_stable_key_code(stable),
        .o_previous_key_code(prev), .o_key_changed_flag(chg),
        .o_debounce_done_flag(done));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic samples(input logic [7:0] v, input int n);
        repeat (n) begin
            @(posedge clk);
            #1 go = 1'b1;
            val = v;
            @(posedge clk);
            #1 go = 1'b0;
        end
    endtask

    task automatic do_reset();
        @(posedge clk);
        #1 rst = 1'b1;
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        rst = 1'b1; ce = 1'b1; go = 1'b0; clr = 1'b0; val = 8'h00;
        do_reset();
        `CHK("stable", 5'h10, stable)
        `CHK("prev", 5'h10, prev)
        `CHK("flags", 2'b00, {chg, done})
        samples(8'hF8, 4);
        `CHK("done", 1'b0, done)
        samples(8'hFF, 1);
        `CHK("done", 1'b1, done)
        `CHK("chg", 1'b0, chg)
        samples(8'h30, 4);
        `CHK("early", 6'h10, {done, stable})
        samples(8'h37, 1);
        `CHK("settled", 7'h63, {done, chg, stable})
        samples(8'h2F, 1);
        `CHK("held", 12'hC63, {done, chg, prev, stable})
        repeat (10) @(posedge clk);
        `CHK("sticky", 1'b1, chg)
        #1 clr = 1'b1;
        @(posedge clk);
        #1 clr = 1'b0;
        `CHK("cleared", 1'b0, chg)
        samples(8'h40, 1);
        `CHK("restart", 7'h04, {done, chg, prev})
        samples(8'h30, 4);
        `CHK("bounce", 7'h03, {done, chg, prev})
        samples(8'h30, 1);
        `CHK("same key", 7'h43, {done, chg, stable})
        ce = 1'b0;
        samples(8'h70, 1);
        `CHK("frozen", 5'h03, prev)
        ce = 1'b1;
        for (int i = 0; i < 17; i++) begin
            lo = (i == 0) ? 8'h00 : 8'(i * 16 - 8);
            hi = (i == 16) ? 8'hFF : 8'(i * 16 + 7);
            samples(lo, 1);
            `CHK("code lo", 5'(i), prev)
            samples(hi, 1);
            `CHK("code hi", 5'(i), prev)
        end
        samples(8'hFF, 2);
        @(posedge clk);
        #1 go = 1'b1;
        val = 8'hFF;
        clr = 1'b1;
        @(posedge clk);
        #1 go = 1'b0;
        clr = 1'b0;
        `CHK("set wins", 7'h70, {done, chg, stable})
        complete_run();
    end

    // ************************************************************
    // watchdog
    // ************************************************************
    initial begin
        #1_000_000;
        n_errors++;
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
